// ---- lar_pkg.sv ----
// Function
// - Bit 7 of the second-left-line routing register selects single-ended (0) or differential (1), reset 0.
// - Bits 6:3 of the second-left-line register hold the mix level, reset 1111 meaning disconnected.
// - Writing a valid gain code to the second-left-line level connects that input to the mixer.
// - Level codes 0000 to 1000 mean 0 dB down to -12 dB in -1.5 dB steps.
// - Bit 2 of the second-left-line register enables weak common-mode bias of unselected inputs, reset 0.
// - Low reserved bits (1:0 and 2:0) are read-only zero and software writes zeros there.
// - Bit 7 of the first-right-line register selects single-ended (0) or differential (1), reset 0.
// - Bits 6:3 of the first-right-line register hold the mix level, reset 1111 meaning disconnected.
// - Writing a valid gain code to the first-right-line level connects that input to the mixer.
package lar_pkg;
  localparam logic [7:0] LAR_SECOND_LEFT_OFFSET = 8'h14;
  localparam logic [7:0] LAR_FIRST_RIGHT_OFFSET = 8'h15;
  localparam int LAR_MODE_BIT = 7;
  localparam int LAR_LEVEL_HI = 6;
  localparam int LAR_LEVEL_LO = 3;
  localparam int LAR_BIAS_BIT = 2;
  localparam logic [3:0] LAR_LEVEL_OFF = 4'hf;
  localparam logic [3:0] LAR_LEVEL_MAX_GAIN = 4'h8;
  localparam logic LAR_MODE_RESET = 1'h0;
  localparam logic LAR_BIAS_RESET = 1'h0;
  // Attenuation in half-dB units per code step (1.5 dB = 3)
  localparam logic [4:0] LAR_STEP_HALF_DB = 5'h03;

  typedef struct packed {
    logic diffMode;
    logic [3:0] level;
  } lar_route_s;

  typedef struct packed {
    lar_route_s secondLeft;
    logic weakBias;
    lar_route_s firstRight;
    logic [7:0] readData;
  } lar_state_s;

  typedef struct packed {
    logic diffMode;
    logic connected;
    logic [4:0] attenHalfDb;
  } lar_path_s;
endpackage

// ---- lar_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
module lar_regs
  import lar_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clkEn,
  // Register port
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  // Mixer controls
  output lar_path_s secondLeftLineInput,
  output lar_path_s firstRightLineInput,
  output logic weakBiasEn
);
  lar_state_s st;
  lar_state_s next_st;

  function automatic lar_path_s decodePath(input lar_route_s r);
    lar_path_s p;
    p.diffMode = r.diffMode;
    // Any code at or below the max gain code connects; 1111 disconnects
    p.connected = (r.level <= LAR_LEVEL_MAX_GAIN);
    // Reserved codes also leave the input off: safest for the mixer
    p.attenHalfDb = p.connected ? 5'(r.level * LAR_STEP_HALF_DB) : 5'h00;
    return p;
  endfunction

  always_comb
  begin
    next_st = st;
    if (regWrite && regAddr == LAR_SECOND_LEFT_OFFSET)
    begin
      next_st.secondLeft.diffMode = regWriteData[LAR_MODE_BIT];
      next_st.secondLeft.level = regWriteData[LAR_LEVEL_HI:LAR_LEVEL_LO];
      next_st.weakBias = regWriteData[LAR_BIAS_BIT];
    end
    if (regWrite && regAddr == LAR_FIRST_RIGHT_OFFSET)
    begin
      next_st.firstRight.diffMode = regWriteData[LAR_MODE_BIT];
      next_st.firstRight.level = regWriteData[LAR_LEVEL_HI:LAR_LEVEL_LO];
    end
    if (regRead)
    begin
      // Low bits are not stored, so they always read zero
      case (regAddr)
        LAR_SECOND_LEFT_OFFSET: next_st.readData = {st.secondLeft, st.weakBias, 2'h0};
        LAR_FIRST_RIGHT_OFFSET: next_st.readData = {st.firstRight, 3'h0};
        default: next_st.readData = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      st <= '{secondLeft: '{diffMode: LAR_MODE_RESET, level: LAR_LEVEL_OFF}, weakBias: LAR_BIAS_RESET,
              firstRight: '{diffMode: LAR_MODE_RESET, level: LAR_LEVEL_OFF}, readData: 8'h00};
    end
    else if (clkEn)
    begin
      st <= next_st;
    end
  end

  assign regReadData = st.readData;
  assign secondLeftLineInput = decodePath(st.secondLeft);
  assign firstRightLineInput = decodePath(st.firstRight);
  assign weakBiasEn = st.weakBias;

  sequence wrSecondLeft;
    resetn && clkEn && regWrite && regAddr == LAR_SECOND_LEFT_OFFSET;
  endsequence

  sequence wrFirstRight;
    resetn && clkEn && regWrite && regAddr == LAR_FIRST_RIGHT_OFFSET;
  endsequence

  sequence frozenCycle;
    resetn && !clkEn;
  endsequence

  sequence keepSecondLeft;
    resetn && !(clkEn && regWrite && regAddr == LAR_SECOND_LEFT_OFFSET);
  endsequence

  sequence keepFirstRight;
    resetn && !(clkEn && regWrite && regAddr == LAR_FIRST_RIGHT_OFFSET);
  endsequence

  sequence rdSecondLeft;
    resetn && clkEn && regRead && regAddr == LAR_SECOND_LEFT_OFFSET;
  endsequence

  sequence rdFirstRight;
    resetn && clkEn && regRead && regAddr == LAR_FIRST_RIGHT_OFFSET;
  endsequence

  sequence rdUnmapped;
    resetn && clkEn && regRead && regAddr != LAR_SECOND_LEFT_OFFSET && regAddr != LAR_FIRST_RIGHT_OFFSET;
  endsequence

  AST_SL_MODE: assert property (@(posedge core_clk) disable iff (!resetn)
    wrSecondLeft |=> secondLeftLineInput.diffMode == $past(regWriteData[LAR_MODE_BIT]))
    else $error("second-left mode not stored");
  AST_SL_LEVEL: assert property (@(posedge core_clk) disable iff (!resetn)
    wrSecondLeft |=> st.secondLeft.level == $past(regWriteData[LAR_LEVEL_HI:LAR_LEVEL_LO]))
    else $error("second-left level not stored");
  AST_SL_CONNECT: assert property (@(posedge core_clk) disable iff (!resetn)
    wrSecondLeft ##0 (regWriteData[LAR_LEVEL_HI:LAR_LEVEL_LO] <= LAR_LEVEL_MAX_GAIN) |=> secondLeftLineInput.connected)
    else $error("second-left not connected by gain code");
  // Three half-dB units per code, written as a sum so the check does not reuse the decode
  AST_ATTEN: assert property (@(posedge core_clk) disable iff (!resetn)
    secondLeftLineInput.connected |->
      secondLeftLineInput.attenHalfDb == 5'({1'b0, st.secondLeft.level} + {st.secondLeft.level, 1'b0}))
    else $error("attenuation decode wrong");
  AST_OFF: assert property (@(posedge core_clk) disable iff (!resetn)
    st.secondLeft.level == LAR_LEVEL_OFF |-> !secondLeftLineInput.connected)
    else $error("disconnect code connected");
  AST_BIAS: assert property (@(posedge core_clk) disable iff (!resetn)
    wrSecondLeft |=> weakBiasEn == $past(regWriteData[LAR_BIAS_BIT]))
    else $error("weak bias not stored");
  AST_RSVD_SL: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(regRead && clkEn && regAddr == LAR_SECOND_LEFT_OFFSET) |-> regReadData[LAR_BIAS_BIT-1:0] == 2'h0)
    else $error("second-left reserved bits nonzero");
  AST_RSVD_FR: assert property (@(posedge core_clk) disable iff (!resetn)
    $past(regRead && clkEn && regAddr == LAR_FIRST_RIGHT_OFFSET) |-> regReadData[LAR_LEVEL_LO-1:0] == 3'h0)
    else $error("first-right reserved bits nonzero");
  AST_FR_MODE: assert property (@(posedge core_clk) disable iff (!resetn)
    wrFirstRight |=> firstRightLineInput.diffMode == $past(regWriteData[LAR_MODE_BIT]))
    else $error("first-right mode not stored");
  AST_FR_LEVEL: assert property (@(posedge core_clk) disable iff (!resetn)
    wrFirstRight |=> st.firstRight.level == $past(regWriteData[LAR_LEVEL_HI:LAR_LEVEL_LO]))
    else $error("first-right level not stored");
  AST_FR_CONNECT: assert property (@(posedge core_clk) disable iff (!resetn)
    wrFirstRight ##0 (regWriteData[LAR_LEVEL_HI:LAR_LEVEL_LO] <= LAR_LEVEL_MAX_GAIN) |=> firstRightLineInput.connected)
    else $error("first-right not connected by gain code");

  // Reset values; no disable here, reset is the antecedent
  AST_RST_SL_MODE: assert property (@(posedge core_clk)
    !resetn |=> !secondLeftLineInput.diffMode)
    else $error("second-left mode reset wrong");
  AST_RST_SL_LEVEL: assert property (@(posedge core_clk)
    !resetn |=> st.secondLeft.level == LAR_LEVEL_OFF)
    else $error("second-left level reset wrong");
  AST_RST_BIAS: assert property (@(posedge core_clk)
    !resetn |=> !weakBiasEn)
    else $error("weak bias reset wrong");
  AST_RST_FR_MODE: assert property (@(posedge core_clk)
    !resetn |=> !firstRightLineInput.diffMode)
    else $error("first-right mode reset wrong");
  AST_RST_FR_LEVEL: assert property (@(posedge core_clk)
    !resetn |=> st.firstRight.level == LAR_LEVEL_OFF)
    else $error("first-right level reset wrong");
  AST_RST_RDATA: assert property (@(posedge core_clk)
    !resetn |=> regReadData == 8'h00)
    else $error("read data reset wrong");

  // Low enable freezes every field
  AST_FREEZE_SL: assert property (@(posedge core_clk) disable iff (!resetn)
    frozenCycle |=> $stable(st.secondLeft))
    else $error("second-left changed while frozen");
  AST_FREEZE_FR: assert property (@(posedge core_clk) disable iff (!resetn)
    frozenCycle |=> $stable(st.firstRight))
    else $error("first-right changed while frozen");
  AST_FREEZE_BIAS: assert property (@(posedge core_clk) disable iff (!resetn)
    frozenCycle |=> $stable(weakBiasEn))
    else $error("weak bias changed while frozen");
  AST_FREEZE_RDATA: assert property (@(posedge core_clk) disable iff (!resetn)
    frozenCycle |=> $stable(regReadData))
    else $error("read data changed while frozen");

  // Fields move only on a write to their own address; read data moves only on a read
  AST_HOLD_SL: assert property (@(posedge core_clk) disable iff (!resetn)
    keepSecondLeft |=> $stable(st.secondLeft))
    else $error("second-left changed without write");
  AST_HOLD_BIAS: assert property (@(posedge core_clk) disable iff (!resetn)
    keepSecondLeft |=> $stable(weakBiasEn))
    else $error("weak bias changed without write");
  AST_HOLD_FR: assert property (@(posedge core_clk) disable iff (!resetn)
    keepFirstRight |=> $stable(st.firstRight))
    else $error("first-right changed without write");
  AST_RDATA_HOLD: assert property (@(posedge core_clk) disable iff (!resetn)
    resetn && !(clkEn && regRead) |=> $stable(regReadData))
    else $error("read data changed without read");

  // Read-back one cycle after the read edge
  AST_RD_SL: assert property (@(posedge core_clk) disable iff (!resetn)
    rdSecondLeft |=> regReadData[LAR_MODE_BIT:LAR_BIAS_BIT] == {$past(st.secondLeft), $past(st.weakBias)})
    else $error("second-left read-back wrong");
  AST_RD_FR: assert property (@(posedge core_clk) disable iff (!resetn)
    rdFirstRight |=> regReadData[LAR_MODE_BIT:LAR_LEVEL_LO] == $past(st.firstRight))
    else $error("first-right read-back wrong");
  AST_RD_UNMAPPED: assert property (@(posedge core_clk) disable iff (!resetn)
    rdUnmapped |=> regReadData == 8'h00)
    else $error("unmapped read not zero");

  // Decode of the stored codes
  AST_FR_ATTEN: assert property (@(posedge core_clk) disable iff (!resetn)
    firstRightLineInput.connected |->
      firstRightLineInput.attenHalfDb == 5'({1'b0, st.firstRight.level} + {st.firstRight.level, 1'b0}))
    else $error("first-right attenuation decode wrong");
  AST_FR_OFF: assert property (@(posedge core_clk) disable iff (!resetn)
    st.firstRight.level == LAR_LEVEL_OFF |-> !firstRightLineInput.connected)
    else $error("first-right disconnect code connected");
  AST_SL_GAIN_ON: assert property (@(posedge core_clk) disable iff (!resetn)
    st.secondLeft.level <= LAR_LEVEL_MAX_GAIN |-> secondLeftLineInput.connected)
    else $error("second-left gain code left open");
  AST_FR_GAIN_ON: assert property (@(posedge core_clk) disable iff (!resetn)
    st.firstRight.level <= LAR_LEVEL_MAX_GAIN |-> firstRightLineInput.connected)
    else $error("first-right gain code left open");
  AST_SL_RSVD_OFF: assert property (@(posedge core_clk) disable iff (!resetn)
    st.secondLeft.level > LAR_LEVEL_MAX_GAIN |-> !secondLeftLineInput.connected)
    else $error("second-left reserved code connected");
  AST_FR_RSVD_OFF: assert property (@(posedge core_clk) disable iff (!resetn)
    st.firstRight.level > LAR_LEVEL_MAX_GAIN |-> !firstRightLineInput.connected)
    else $error("first-right reserved code connected");
  AST_SL_QUIET: assert property (@(posedge core_clk) disable iff (!resetn)
    !secondLeftLineInput.connected |-> secondLeftLineInput.attenHalfDb == 5'h00)
    else $error("second-left attenuation while open");
  AST_FR_QUIET: assert property (@(posedge core_clk) disable iff (!resetn)
    !firstRightLineInput.connected |-> firstRightLineInput.attenHalfDb == 5'h00)
    else $error("first-right attenuation while open");

  // Outputs follow the stored bits
  AST_SL_MODE_OUT: assert property (@(posedge core_clk) disable iff (!resetn)
    secondLeftLineInput.diffMode == st.secondLeft.diffMode)
    else $error("second-left mode output wrong");
  AST_FR_MODE_OUT: assert property (@(posedge core_clk) disable iff (!resetn)
    firstRightLineInput.diffMode == st.firstRight.diffMode)
    else $error("first-right mode output wrong");
  AST_BIAS_OUT: assert property (@(posedge core_clk) disable iff (!resetn)
    weakBiasEn == st.weakBias)
    else $error("weak bias output wrong");
endmodule
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import lar_pkg::*;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic clkEn = 1'b1;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWriteData = 8'h00;
  logic [7:0] regReadData;
  lar_path_s secondLeftLineInput;
  lar_path_s firstRightLineInput;
  logic weakBiasEn;
  logic [7:0] rdv;
  int err_total = 0;
  int n_checks = 0;
  always #2 core_clk = ~core_clk;
  lar_regs lar_regs_i (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn), .regWrite(regWrite),
    .regRead(regRead), .regAddr(regAddr), .regWriteData(regWriteData), .regReadData(regReadData),
    .secondLeftLineInput(secondLeftLineInput), .firstRightLineInput(firstRightLineInput), .weakBiasEn(weakBiasEn));
  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic chkP(input string what, input logic [6:0] exp, input logic [6:0] got);
    n_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    #1 regWrite = 1'b1;
    regAddr = a;
    regWriteData = d;
    @(posedge core_clk);
    #1 regWrite = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk);
    #1 regRead = 1'b1;
    regAddr = a;
    @(posedge core_clk);
    #1 regRead = 1'b0;
    d = regReadData;
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge core_clk);
    #1 resetn = 1'b1;
    rd(8'h14, rdv);
    chk8("reg14", 8'h78, rdv);
    rd(8'h15, rdv);
    chk8("reg15", 8'h78, rdv);
    chkP("secondLeft", 7'h00, secondLeftLineInput);
    chk8("bias", 8'h00, {7'h00, weakBiasEn});
    // Software keeps the low bits zero; they must read back zero
    wr(8'h14, 8'ha4);
    rd(8'h14, rdv);
    chk8("reg14", 8'ha4, rdv);
    chkP("secondLeft", {1'b1, 1'b1, 5'h0c}, secondLeftLineInput);
    chk8("bias", 8'h01, {7'h00, weakBiasEn});
    for (int c = 0; c <= 8; c++)
    begin
      wr(8'h15, {1'b1, 4'(c), 3'h0});
      rd(8'h15, rdv);
      chk8("reg15", {1'b1, 4'(c), 3'h0}, rdv);
      chkP("firstRight", {1'b1, 1'b1, 5'(c * 3)}, firstRightLineInput);
    end
    wr(8'h15, 8'hf8);
    chkP("firstRight", {1'b1, 1'b0, 5'h00}, firstRightLineInput);
    // Frozen cycle must not take the write
    clkEn = 1'b0;
    wr(8'h14, 8'h00);
    clkEn = 1'b1;
    chkP("secondLeft", {1'b1, 1'b1, 5'h0c}, secondLeftLineInput);
    chk8("bias", 8'h01, {7'h00, weakBiasEn});
    rd(8'h14, rdv);
    chk8("reg14", 8'ha4, rdv);
    rd(8'h16, rdv);
    chk8("unmapped", 8'h00, rdv);
    tally_and_finish;
  end
endmodule
`default_nettype wire
